// ==== logic/timer_output_flag_irq_ctrl_regs.svh ====
/*
 Register offsets, field positions and reset values of the timer output, flag and mask block.
 Assumes inclusion by bare name from the package and the design module.
*/
`ifndef TIMER_OUTPUT_FLAG_IRQ_CTRL_REGS_SVH
`define TIMER_OUTPUT_FLAG_IRQ_CTRL_REGS_SVH
`define OUTA_OFS     8'hFC
`define OUTB_OFS     8'hFD
`define FLAGS_OFS    8'hFE
`define MASK_OFS     8'hFF
`define ADDR_W       10
`define RESET_BYTE   8'h00
`define F_M0_HI      7
`define F_M0_LO      6
`define F_M1_HI      5
`define F_M1_LO      4
`define F_WR_HI      3
`define F_WR_LO      2
`define F_EVT_EN     1
`define F_PRESET     0
`define FL_CAP0      7
`define FL_CAP1      6
`define FL_M0        5
`define FL_M1        4
`define FL_WRAP      3
`define FL_OCAP0     2
`define FL_OM0       1
`define FL_AND       0
`define MK_GLOBAL    7
`define MK_CAP0_DMA  6
`define MK_CAP0_IRQ  5
`define MK_CAP1_IRQ  4
`define MK_M0_DMA    3
`define MK_M0_IRQ    2
`define MK_M1_IRQ    1
`define MK_WRAP_IRQ  0
`define ACT_NOP      2'h3
`endif

// ==== logic/timer_ofi_pkg.sv ====
/*
 Types shared by the timer output, flag and mask block.
 Assumes the register header is on the include path.
*/
package timer_ofi_pkg;
`include "timer_output_flag_irq_ctrl_regs.svh"
	typedef logic [1:0] action_t;
	typedef logic [7:0] byte_t;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'h0,
		BUS_ACK  = 2'h1
	} bus_state_t;
endpackage : timer_ofi_pkg

// ==== logic/timer_output_flag_irq_ctrl.sv ====
/*
 Output actions, event flags and interrupt/DMA gating of one multifunction timer, with an
 Avalon-MM slave for its four registers. Assumes counter, compare and capture logic on the same
 clock deliver one-cycle event pulses, and a DMA engine pulses block-end strobes.
*/
`include "timer_output_flag_irq_ctrl_regs.svh"
module timer_output_flag_irq_ctrl (
	// Clock and reset
	input  wire logic                  mclk_i,
	input  wire logic                  nrst_i,
	// Avalon-MM slave
	input  wire logic [`ADDR_W-1:0]    avs_address_i,
	input  wire logic                  avs_read_i,
	input  wire logic                  avs_write_i,
	input  wire logic [31:0]           avs_writedata_i,
	input  wire logic [3:0]            avs_byteenable_i,
	output logic      [31:0]           avs_readdata_o,
	output logic                       avs_waitrequest_o,
	output logic      [1:0]            avs_response_o,
	// Timer events, one-cycle pulses; bicapture mode is a level
	input  wire logic                  match0_i,
	input  wire logic                  match1_i,
	input  wire logic                  wrap_i,
	input  wire logic                  capture0_i,
	input  wire logic                  capture1_i,
	input  wire logic                  bicapture_mode_i,
	input  wire logic                  cap0_dma_eob_i,
	input  wire logic                  m0_dma_eob_i,
	// Pins and requests
	output logic                       timer_output_a_pin_o,
	output logic                       timer_output_b_pin_o,
	output logic                       onchip_event_o,
	output logic                       soft_capture0_o,
	output logic                       soft_capture1_o,
	output logic                       capture_irq_o,
	output logic                       match_irq_o,
	output logic                       wrap_irq_o,
	output logic                       cap0_dma_req_o,
	output logic                       m0_dma_req_o
);
	import timer_ofi_pkg::*;

	timer_ofi_pkg::byte_t outa_reg;
	timer_ofi_pkg::byte_t outb_reg;
	timer_ofi_pkg::byte_t flags_reg;
	timer_ofi_pkg::byte_t mask_reg;
	timer_ofi_pkg::bus_state_t bus_reg;
	logic                pin_a_reg;
	logic                pin_b_reg;

	// Word-aligned decode: one register per 32-bit word
	logic [`ADDR_W-3:0] word_idx;
	logic               hit_a;
	logic               hit_b;
	logic               hit_f;
	logic               hit_m;
	logic               wr_go;
	logic               wr_lane0;
	assign word_idx = avs_address_i[`ADDR_W-1:2];
	assign hit_a    = (word_idx == `OUTA_OFS);
	assign hit_b    = (word_idx == `OUTB_OFS);
	assign hit_f    = (word_idx == `FLAGS_OFS);
	assign hit_m    = (word_idx == `MASK_OFS);
	// Waitrequest is low for one cycle: a request completes on the second edge
	assign wr_go    = avs_write_i && (bus_reg == BUS_ACK);
	assign wr_lane0 = wr_go && avs_byteenable_i[0];

	logic [7:0] wdat;
	assign wdat = avs_writedata_i[7:0];

	// Pin action resolution
	function automatic logic next_pin(input logic cur, input byte_t ctl,
	                                  input logic e0, input logic e1, input logic ew);
		action_t act;
		act = `ACT_NOP;
		if (e0) act = act & ctl[`F_M0_HI:`F_M0_LO];
		if (e1) act = act & ctl[`F_M1_HI:`F_M1_LO];
		if (ew) act = act & ctl[`F_WR_HI:`F_WR_LO];
		case (act)
			2'h0:    next_pin = 1'b1;
			2'h1:    next_pin = ~cur;
			2'h2:    next_pin = 1'b0;
			default: next_pin = cur;
		endcase
	endfunction : next_pin

	logic any_a;
	assign any_a = match0_i | match1_i | wrap_i;

	// Pin A: software preset write loads the pin, hardware events take priority
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			pin_a_reg <= 1'b0;
		end else if (any_a) begin
			pin_a_reg <= next_pin(pin_a_reg, outa_reg, match0_i, match1_i, wrap_i);
		end else if (wr_lane0 && hit_a) begin
			pin_a_reg <= wdat[`F_PRESET];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			pin_b_reg <= 1'b0;
		end else if (any_a) begin
			pin_b_reg <= next_pin(pin_b_reg, outb_reg, match0_i, match1_i, wrap_i);
		end else if (wr_lane0 && hit_b) begin
			pin_b_reg <= wdat[`F_PRESET];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			outa_reg <= `RESET_BYTE;
			outb_reg <= `RESET_BYTE;
		end else begin
			if (wr_lane0 && hit_a) outa_reg <= wdat;
			if (wr_lane0 && hit_b) outb_reg <= wdat;
		end
	end

	// On-chip event: one pulse per cycle with an enabled match0 (OUTA) or wrap (OUTB) event
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			onchip_event_o <= 1'b0;
		end else begin
			onchip_event_o <= (match0_i && outa_reg[`F_EVT_EN])
			               || (wrap_i && outb_reg[`F_EVT_EN]);
		end
	end

	// Flags: hardware set wins over software clear
	logic sw_flag_wr;
	logic sw_cap0;
	logic sw_cap1;
	logic cap0_ev;
	logic cap1_ev;
	assign sw_flag_wr = wr_lane0 && hit_f;
	assign sw_cap0    = sw_flag_wr && wdat[`FL_CAP0];
	assign sw_cap1    = sw_flag_wr && wdat[`FL_CAP1] && !bicapture_mode_i;
	assign cap0_ev    = capture0_i | sw_cap0;
	assign cap1_ev    = capture1_i | sw_cap1;

	function automatic logic flag_next(input logic cur, input logic set,
	                                   input logic wr, input logic wbit);
		flag_next = set | (cur & ~(wr & ~wbit));
	endfunction : flag_next

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			flags_reg <= `RESET_BYTE;
		end else begin
			flags_reg[`FL_CAP0]  <= flag_next(flags_reg[`FL_CAP0], cap0_ev, sw_flag_wr, 1'b0);
			flags_reg[`FL_CAP1]  <= flag_next(flags_reg[`FL_CAP1], cap1_ev, sw_flag_wr, 1'b0);
			flags_reg[`FL_M0]    <= flag_next(flags_reg[`FL_M0], match0_i, sw_flag_wr, 1'b0);
			flags_reg[`FL_M1]    <= flag_next(flags_reg[`FL_M1], match1_i, sw_flag_wr, 1'b0);
			flags_reg[`FL_WRAP]  <= flag_next(flags_reg[`FL_WRAP], wrap_i, sw_flag_wr, 1'b0);
			flags_reg[`FL_OCAP0] <= flag_next(flags_reg[`FL_OCAP0],
			                        (capture0_i && flags_reg[`FL_CAP0]) || sw_cap0,
			                        sw_flag_wr, 1'b0);
			flags_reg[`FL_OM0]   <= flag_next(flags_reg[`FL_OM0],
			                        match0_i && flags_reg[`FL_M0], sw_flag_wr, 1'b0);
			if (sw_flag_wr) flags_reg[`FL_AND] <= wdat[`FL_AND];
		end
	end

	// Mask register: DMA enables cleared by block end, which wins over a software set
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			mask_reg <= `RESET_BYTE;
		end else begin
			if (wr_lane0 && hit_m) mask_reg <= wdat;
			if (cap0_dma_eob_i) mask_reg[`MK_CAP0_DMA] <= 1'b0;
			if (m0_dma_eob_i)   mask_reg[`MK_M0_DMA]   <= 1'b0;
		end
	end

	// Interrupt and DMA requests, registered
	logic cap_src0;
	logic cap_src1;
	logic cap_int;
	logic m0_int;
	assign cap_src0 = mask_reg[`MK_CAP0_DMA] ? cap0_dma_eob_i : flags_reg[`FL_CAP0];
	assign cap_src1 = flags_reg[`FL_CAP1];
	// AND mode relies on software enabling both capture masks
	assign cap_int  = flags_reg[`FL_AND]
	                ? (cap_src0 && mask_reg[`MK_CAP0_IRQ]) && (cap_src1 && mask_reg[`MK_CAP1_IRQ])
	                : (cap_src0 && mask_reg[`MK_CAP0_IRQ]) || (cap_src1 && mask_reg[`MK_CAP1_IRQ]);
	assign m0_int   = (mask_reg[`MK_M0_DMA] ? m0_dma_eob_i : flags_reg[`FL_M0]) && mask_reg[`MK_M0_IRQ];

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			capture_irq_o  <= 1'b0;
			match_irq_o    <= 1'b0;
			wrap_irq_o     <= 1'b0;
			cap0_dma_req_o <= 1'b0;
			m0_dma_req_o   <= 1'b0;
		end else begin
			capture_irq_o  <= mask_reg[`MK_GLOBAL] && cap_int;
			match_irq_o    <= mask_reg[`MK_GLOBAL] && (m0_int
			                  || (flags_reg[`FL_M1] && mask_reg[`MK_M1_IRQ]));
			wrap_irq_o     <= mask_reg[`MK_GLOBAL] && flags_reg[`FL_WRAP]
			                  && mask_reg[`MK_WRAP_IRQ];
			cap0_dma_req_o <= capture0_i && mask_reg[`MK_CAP0_DMA];
			m0_dma_req_o   <= match0_i && mask_reg[`MK_M0_DMA];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			soft_capture0_o <= 1'b0;
			soft_capture1_o <= 1'b0;
		end else begin
			soft_capture0_o <= sw_cap0;
			soft_capture1_o <= sw_cap1;
		end
	end

	// Bus slave: one wait cycle, then answer
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			bus_reg <= BUS_IDLE;
		end else begin
			case (bus_reg)
				BUS_IDLE: if (avs_read_i || avs_write_i) bus_reg <= BUS_ACK;
				BUS_ACK:  bus_reg <= BUS_IDLE;
				default:  bus_reg <= BUS_IDLE;
			endcase
		end
	end

	// Reads of the preset bit show the live pin level
	byte_t rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		if (hit_a) rd_byte = {outa_reg[7:1], pin_a_reg};
		if (hit_b) rd_byte = {outb_reg[7:1], pin_b_reg};
		if (hit_f) rd_byte = flags_reg;
		if (hit_m) rd_byte = mask_reg;
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h0000_0000;
			avs_response_o    <= 2'h0;
		end else begin
			avs_waitrequest_o <= !((avs_read_i || avs_write_i) && bus_reg == BUS_IDLE);
			avs_readdata_o    <= {24'h00_0000, rd_byte};
			avs_response_o    <= (hit_a || hit_b || hit_f || hit_m) ? 2'h0 : 2'h2;
		end
	end

	// Assertions
	sequence s_match0_enabled;
		match0_i && outa_reg[`F_EVT_EN];
	endsequence
	sequence s_pulse_out;
		##1 onchip_event_o;
	endsequence

	AST_EVT_PULSE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		s_match0_enabled |-> s_pulse_out) else $error("match0 event pulse missing");
	AST_WRAP_PULSE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		wrap_i && outb_reg[`F_EVT_EN] |=> onchip_event_o) else $error("wrap event pulse missing");
	AST_NO_PULSE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		!match0_i && !wrap_i |=> !onchip_event_o) else $error("spurious event pulse");
	AST_SET_ACT: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		match0_i && !match1_i && !wrap_i && outa_reg[`F_M0_HI:`F_M0_LO] == 2'h0 |=> timer_output_a_pin_o)
		else $error("set action failed");
	AST_TOGGLE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		match0_i && wrap_i && !match1_i && outb_reg[`F_M0_HI:`F_M0_LO] == 2'h1
		&& outb_reg[`F_WR_HI:`F_WR_LO] == `ACT_NOP
		|=> timer_output_b_pin_o != $past(timer_output_b_pin_o)) else $error("combined toggle failed");
	AST_CAP0_SET: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		capture0_i |=> flags_reg[`FL_CAP0]) else $error("capture flag lost");
	AST_OVERRUN: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		match0_i && flags_reg[`FL_M0] |=> flags_reg[`FL_OM0]) else $error("match overrun not set");
	AST_GLOBAL: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		!mask_reg[`MK_GLOBAL] |=> !capture_irq_o && !match_irq_o && !wrap_irq_o)
		else $error("interrupt passed while globally disabled");
	AST_DMA_CLR: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		cap0_dma_eob_i |=> !mask_reg[`MK_CAP0_DMA]) else $error("dma enable not cleared");
	AST_WRAP_IRQ: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		wrap_i && mask_reg[`MK_GLOBAL] && mask_reg[`MK_WRAP_IRQ] && !(wr_lane0 && hit_m) |-> ##2 wrap_irq_o)
		else $error("wrap interrupt missing");

	assign timer_output_a_pin_o = pin_a_reg;
	assign timer_output_b_pin_o = pin_b_reg;
endmodule : timer_output_flag_irq_ctrl

// ==== verif/timer_output_flag_irq_ctrl_tb_top.sv ====
/*
 Self-checking bench for the timer output, flag and mask block: register access, pin actions,
 event pulses, flags, overruns, interrupt gating and DMA masks.
 Assumes the package and register header are compiled first and on the include path.
*/
`include "timer_output_flag_irq_ctrl_regs.svh"
module timer_output_flag_irq_ctrl_tb_top
	import timer_ofi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [`ADDR_W-1:0] A_OUTA = {`OUTA_OFS, 2'b00};
	localparam logic [`ADDR_W-1:0] A_OUTB = {`OUTB_OFS, 2'b00};
	localparam logic [`ADDR_W-1:0] A_FLG  = {`FLAGS_OFS, 2'b00};
	localparam logic [`ADDR_W-1:0] A_MSK  = {`MASK_OFS, 2'b00};
	localparam logic [6:0] EV_M0 = 7'h40, EV_M1 = 7'h20, EV_WR = 7'h10, EV_C0 = 7'h08;
	localparam logic [6:0] EV_C1 = 7'h04, EV_E0 = 7'h02, EV_E1 = 7'h01;
	logic               mclk_i, nrst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
	logic [`ADDR_W-1:0] avs_address_i;
	logic [31:0]        avs_writedata_i, avs_readdata_o;
	logic [3:0]         avs_byteenable_i;
	logic [1:0]         avs_response_o, r;
	logic               match0_i, match1_i, wrap_i, capture0_i, capture1_i, bicapture_mode_i;
	logic               cap0_dma_eob_i, m0_dma_eob_i, pin_a, pin_b, onchip_event_o;
	logic               soft_capture0_o, soft_capture1_o, capture_irq_o, match_irq_o, wrap_irq_o;
	logic               cap0_dma_req_o, m0_dma_req_o, e;
	logic [7:0]         ev_cnt = '0, s0_cnt = '0, s1_cnt = '0, d0_cnt = '0, d1_cnt = '0;
	byte_t              q, v, base;
	int                 bad_count = 0, comparisons = 0;

	timer_output_flag_irq_ctrl uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o), .match0_i(match0_i),
		.match1_i(match1_i), .wrap_i(wrap_i), .capture0_i(capture0_i), .capture1_i(capture1_i),
		.bicapture_mode_i(bicapture_mode_i), .cap0_dma_eob_i(cap0_dma_eob_i), .m0_dma_eob_i(m0_dma_eob_i),
		.timer_output_a_pin_o(pin_a), .timer_output_b_pin_o(pin_b), .onchip_event_o(onchip_event_o),
		.soft_capture0_o(soft_capture0_o), .soft_capture1_o(soft_capture1_o),
		.capture_irq_o(capture_irq_o), .match_irq_o(match_irq_o), .wrap_irq_o(wrap_irq_o),
		.cap0_dma_req_o(cap0_dma_req_o), .m0_dma_req_o(m0_dma_req_o));

	initial begin
		mclk_i = 1'b0;
		forever #4 mclk_i = ~mclk_i;
	end

	// Pulse counters use non-blocking updates so the main flow reads them race-free
	always @(posedge mclk_i) begin
		ev_cnt <= ev_cnt + {7'h00, onchip_event_o === 1'b1};
		s0_cnt <= s0_cnt + {7'h00, soft_capture0_o === 1'b1};
		s1_cnt <= s1_cnt + {7'h00, soft_capture1_o === 1'b1};
		d0_cnt <= d0_cnt + {7'h00, cap0_dma_req_o === 1'b1};
		d1_cnt <= d1_cnt + {7'h00, m0_dma_req_o === 1'b1};
	end

	task automatic wrap_up;
		if (bad_count == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : wrap_up

	task automatic chk8(input byte_t got, input byte_t exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk8

	task automatic chk1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk1

	// Holds the request until waitrequest is sampled low; bounded so a dead slave ends the run
	task automatic bus(input logic rd, input logic [`ADDR_W-1:0] a, input byte_t wd);
		int n;
		n = 0;
		avs_address_i <= a;
		avs_read_i <= rd;
		avs_write_i <= !rd;
		avs_writedata_i <= {24'h000000, wd};
		do begin
			@(posedge mclk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		q = avs_readdata_o[7:0];
		r = avs_response_o;
		if (avs_waitrequest_o !== 1'b0) begin
			bad_count++;
			wrap_up();
		end
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge mclk_i);
	endtask : bus

	task automatic wr(input logic [`ADDR_W-1:0] a, input byte_t d);
		bus(1'b0, a, d);
	endtask : wr

	task automatic rd_chk(input logic [`ADDR_W-1:0] a, input byte_t exp);
		bus(1'b1, a, 8'h00);
		chk8(q, exp);
		chk8({6'h00, r}, 8'h00);
	endtask : rd_chk

	task automatic settle;
		repeat (3) @(posedge mclk_i);
	endtask : settle

	task automatic pulse(input logic [6:0] ev);
		{match0_i, match1_i, wrap_i, capture0_i, capture1_i, cap0_dma_eob_i, m0_dma_eob_i} <= ev;
		@(posedge mclk_i);
		{match0_i, match1_i, wrap_i, capture0_i, capture1_i, cap0_dma_eob_i, m0_dma_eob_i} <= 7'h00;
		settle();
	endtask : pulse

	initial begin
		nrst_i = 1'b0;
		{avs_read_i, avs_write_i, bicapture_mode_i} = 3'h0;
		avs_address_i = '0;
		avs_writedata_i = 32'h00000000;
		avs_byteenable_i = 4'hF;
		{match0_i, match1_i, wrap_i, capture0_i, capture1_i, cap0_dma_eob_i, m0_dma_eob_i} = 7'h00;
		repeat (20) @(posedge mclk_i);
		nrst_i <= 1'b1;
		@(posedge mclk_i);
		chk1(avs_waitrequest_o, 1'b1);
		rd_chk(A_OUTA, 8'h00);
		rd_chk(A_OUTB, 8'h00);
		rd_chk(A_FLG, 8'h00);
		rd_chk(A_MSK, 8'h00);
		// A write without lane 0 must leave the register alone
		avs_byteenable_i <= 4'hE;
		wr(A_MSK, 8'hFF);
		avs_byteenable_i <= 4'hF;
		rd_chk(A_MSK, 8'h00);
		bus(1'b1, 10'h000, 8'h00);
		chk8(q, 8'h00);
		chk8({6'h00, r}, 8'h02);
		// Each field and code on each pin; preset picks a start level that exposes the action
		for (int p = 0; p < 2; p++) begin
			for (int f = 0; f < 3; f++) begin
				for (int c = 0; c < 4; c++) begin
					v = 8'hFC;
					v[7 - 2 * f -: 2] = c[1:0];
					v[0] = (c != 0);
					wr(p ? A_OUTB : A_OUTA, v);
					pulse(EV_M0 >> f);
					case (c)
						0: e = 1'b1;
						1: e = ~v[0];
						2: e = 1'b0;
						default: e = v[0];
					endcase
					chk1(p ? pin_b : pin_a, e);
					rd_chk(p ? A_OUTB : A_OUTA, {v[7:1], e});
				end
			end
		end
		wr(A_OUTA, 8'h6C);
		wr(A_OUTB, 8'h6C);
		pulse(EV_M0 | EV_M1);
		chk1(pin_a, 1'b1);
		chk1(pin_b, 1'b1);
		wr(A_OUTB, 8'h7C);
		pulse(EV_M0 | EV_WR);
		chk1(pin_b, 1'b1);
		wr(A_OUTA, 8'hFE);
		wr(A_OUTB, 8'hFC);
		base = ev_cnt;
		pulse(EV_M0);
		chk8(ev_cnt - base, 8'h01);
		pulse(EV_WR);
		chk8(ev_cnt - base, 8'h01);
		wr(A_OUTB, 8'hFE);
		pulse(EV_WR);
		chk8(ev_cnt - base, 8'h02);
		wr(A_FLG, 8'h00);
		pulse(EV_M0 | EV_M1 | EV_WR | EV_C0 | EV_C1);
		rd_chk(A_FLG, 8'hF8);
		pulse(EV_C0);
		rd_chk(A_FLG, 8'hFC);
		wr(A_FLG, 8'h00);
		rd_chk(A_FLG, 8'h00);
		base = s0_cnt;
		wr(A_FLG, 8'h80);
		settle();
		chk8(s0_cnt - base, 8'h01);
		rd_chk(A_FLG, 8'h84);
		wr(A_FLG, 8'h00);
		bicapture_mode_i <= 1'b1;
		base = s1_cnt;
		wr(A_FLG, 8'h40);
		settle();
		chk8(s1_cnt - base, 8'h00);
		bicapture_mode_i <= 1'b0;
		wr(A_FLG, 8'h40);
		settle();
		chk8(s1_cnt - base, 8'h01);
		wr(A_FLG, 8'h00);
		wr(A_MSK, 8'h84);
		pulse(EV_M0);
		chk1(match_irq_o, 1'b1);
		pulse(EV_M0);
		rd_chk(A_FLG, 8'h22);
		wr(A_FLG, 8'h00);
		wr(A_MSK, 8'h00);
		pulse(EV_WR);
		chk1(wrap_irq_o, 1'b0);
		wr(A_MSK, 8'h01);
		settle();
		chk1(wrap_irq_o, 1'b0);
		wr(A_MSK, 8'h81);
		settle();
		chk1(wrap_irq_o, 1'b1);
		wr(A_FLG, 8'h00);
		settle();
		chk1(wrap_irq_o, 1'b0);
		pulse(EV_WR);
		chk1(wrap_irq_o, 1'b1);
		wr(A_MSK, 8'h82);
		pulse(EV_M1);
		chk1(match_irq_o, 1'b1);
		wr(A_FLG, 8'h00);
		wr(A_MSK, 8'hB0);
		pulse(EV_C0);
		chk1(capture_irq_o, 1'b1);
		wr(A_FLG, 8'h01);
		pulse(EV_C0);
		chk1(capture_irq_o, 1'b0);
		pulse(EV_C1);
		chk1(capture_irq_o, 1'b1);
		wr(A_FLG, 8'h00);
		wr(A_MSK, 8'hB7);
		rd_chk(A_MSK, 8'hB7);
		wr(A_MSK, 8'h48);
		rd_chk(A_MSK, 8'h48);
		base = d0_cnt;
		pulse(EV_C0);
		chk8(d0_cnt - base, 8'h01);
		base = d1_cnt;
		pulse(EV_M0);
		chk8(d1_cnt - base, 8'h01);
		// Under DMA the flags do not interrupt; block end hands the source back to the flag
		wr(A_MSK, 8'hEC);
		settle();
		chk1(capture_irq_o, 1'b0);
		chk1(match_irq_o, 1'b0);
		pulse(EV_E0);
		chk1(capture_irq_o, 1'b1);
		rd_chk(A_MSK, 8'hAC);
		pulse(EV_E1);
		chk1(match_irq_o, 1'b1);
		rd_chk(A_MSK, 8'hA4);
		wrap_up();
	end
endmodule : timer_output_flag_irq_ctrl_tb_top
